//--- hw/uat_fifo.sv
`timescale 1ns/1ps

module uat_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic flush,
  // streams
  uat_stream_if.sink   inPort,
  uat_stream_if.source outPort
);

  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin
      $error("uat_fifo: DEPTH must be a power of two, at least 2");
    end
    if (WIDTH < 1) begin
      $error("uat_fifo: WIDTH must be positive");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_ff;
  logic [PW-1:0]    rdPtr_ff;
  logic [PW:0]      count_ff;
  logic             outValid_ff;
  logic [WIDTH-1:0] outData_ff;

  wire pushEn = inPort.valid && inPort.ready;
  // the output stage is refilled whenever it is empty or being taken
  wire popEn  = (count_ff != '0) && (!outValid_ff || outPort.ready);

  assign inPort.ready  = (count_ff != (PW+1)'(DEPTH)) && !flush;
  assign outPort.valid = outValid_ff;
  assign outPort.data  = outData_ff;

  always_ff @(posedge clk) begin
    if (pushEn) begin
      mem[wrPtr_ff] <= inPort.data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_ff    <= '0;
      rdPtr_ff    <= '0;
      count_ff    <= '0;
      outValid_ff <= 1'b0;
      outData_ff  <= '0;
    end else if (flush) begin
      wrPtr_ff    <= '0;
      rdPtr_ff    <= '0;
      count_ff    <= '0;
      outValid_ff <= 1'b0;
    end else begin
      if (pushEn) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (popEn) begin
        rdPtr_ff    <= rdPtr_ff + 1'b1;
        outData_ff  <= mem[rdPtr_ff];
        outValid_ff <= 1'b1;
      end else if (outPort.ready) begin
        outValid_ff <= 1'b0;
      end
      count_ff <= count_ff + (PW+1)'(pushEn) - (PW+1)'(popEn);
    end
  end

endmodule // uat_fifo

//--- hw/uat_pkg.sv
package uat_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS       = 20;
  localparam int INSTR_CYCLE_NS      = 20;
  // least time, so round up, never below one clock
  localparam int INSTR_CYCLE_CLKS    = ((INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                       ((INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int FLAG_CLEAR_INSTR    = 2;
  localparam int FLAG_CLEAR_CLKS     = FLAG_CLEAR_INSTR * INSTR_CYCLE_CLKS;

  // ==========================================================
  // frame format
  localparam int DATA_BITS_NARROW    = 8;
  localparam int DATA_BITS_WIDE      = 9;
  localparam int CHAR_WIDTH          = 9;
  localparam int NINTH_BIT_POS       = 8;
  localparam int FIFO_DEPTH          = 16;
  localparam logic MARK_LEVEL        = 1'b1;
  localparam logic SPACE_LEVEL       = 1'b0;

  // ==========================================================
  // reset values
  localparam logic [8:0] HOLD_RESET  = 9'h000;
  localparam logic [8:0] SHIFT_RESET = 9'h000;

  // ==========================================================
  // transmit sequencer
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_START = 5'h02,
    ST_DATA  = 5'h04,
    ST_STOP  = 5'h08,
    ST_GAP   = 5'h10
  } uat_state_type;

endpackage

//--- hw/uat_stream_if.sv
`timescale 1ns/1ps

// valid/ready word stream between the fifo and the transmitter core
interface uat_stream_if #(
  parameter int WIDTH = 9
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (
    output valid,
    output data,
    input  ready
  );

  modport sink (
    input  valid,
    input  data,
    output ready
  );
endinterface // uat_stream_if

//--- hw/uat_tx.sv
//
// Functional notes
// R01: line idles at mark level whenever no character is in flight
// R02: frame is one start bit, 8 or 9 data bits, one stop bit
// R03: data bits leave least significant bit first
// R04: transmitter uses frame format and baud tick shared with receiver
// R05: no parity is generated; software may use the ninth bit
// R06: bit timing comes from the shared baud generator tick input
// R07: transmit active only with port enabled, transmit enabled, async mode
// R08: when transmit active the transmit pin is driven regardless of direction bit
// R09: when receive active the receive pin is forced to input
// R10: holding write starts transmission; loads shift register at once when idle
// R11: waiting character moves one instruction cycle after stop bit ends
// R12: loaded character starts its start bit immediately
// R13: buffer empty flag set while enabled and holding register empty
// R14: buffer empty flag clears only at second instruction cycle after fill
// R15: buffer empty flag is read only, no software write path
// R16: interrupt enable gates request only, flag ignores it
// R17: software sets interrupt enable only while it has data to send
// R18: shift empty status clears on load, sets after stop bit, no interrupt
// R19: nine bit mode sends ninth bit field as most significant data bit
// R20: software writes ninth bit first; holding write captures all nine bits
// R21: setting transmit enable makes the buffer empty flag set
// R22: address frames are marked by ninth bit set by sender
// R23: polarity select inverts every transmitted bit on the pin
// R24: clearing serial port enable resets the whole transmit path
// R25: each bit lasts one baud tick period; the start bit ends at the first tick after load, so it can be shorter
`timescale 1ns/1ps

module uat_tx #(
  parameter int FIFO_DEPTH = uat_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // control bits
  input  wire logic       serialPortEnable,
  input  wire logic       transmitEnableBit,
  input  wire logic       receiveEnableBit,
  input  wire logic       syncModeSelect,
  input  wire logic       clockPolaritySelect,
  input  wire logic       nineBitTxEnable,
  input  wire logic       txNinthBit,
  input  wire logic       txIrqEnable,
  // baud generator
  input  wire logic       baudTick,
  // holding register writes
  input  wire logic       holdWrValid,
  input  wire logic [7:0] holdWrData,
  output logic            holdWrReady,
  // status
  output logic            txBufferEmptyFlag,
  output logic            shiftEmptyStatus,
  output logic            txIrqRequest,
  // transmit pin
  input  wire logic       pinDirectionBitTx,
  input  wire logic       portLatchTx,
  output logic            transmitPinOut,
  output logic            transmitPinOe,
  // receive pin direction
  input  wire logic       pinDirectionBitRx,
  output logic            receivePinOe
);

  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("uat_tx: FIFO_DEPTH too small");
    end
  end

  localparam int GAP_W = $clog2(uat_pkg::INSTR_CYCLE_CLKS + 1);
  localparam int FLG_W = $clog2(uat_pkg::FLAG_CLEAR_CLKS + 1);
  localparam logic [GAP_W-1:0] GAP_LAST  = GAP_W'(uat_pkg::INSTR_CYCLE_CLKS - 1);
  localparam logic [FLG_W-1:0] FLG_LIMIT = FLG_W'(uat_pkg::FLAG_CLEAR_CLKS - 1);
  localparam logic [3:0] BITS_NARROW = 4'(uat_pkg::DATA_BITS_NARROW);
  localparam logic [3:0] BITS_WIDE   = 4'(uat_pkg::DATA_BITS_WIDE);

  // ==========================================================
  // enables and pin direction
  wire portClear = !serialPortEnable; // R24
  wire txActive  = serialPortEnable && transmitEnableBit && !syncModeSelect; // R07
  wire rxActive  = serialPortEnable && receiveEnableBit && !syncModeSelect;

  assign transmitPinOe = txActive ? 1'b1 : !pinDirectionBitTx; // R08
  assign receivePinOe  = rxActive ? 1'b0 : !pinDirectionBitRx; // R09

  // ==========================================================
  // write buffer in front of the holding register
  uat_stream_if #(.WIDTH(uat_pkg::CHAR_WIDTH)) wrStream ();
  uat_stream_if #(.WIDTH(uat_pkg::CHAR_WIDTH)) rdStream ();

  // ninth bit is sampled with the low byte, so it must already be set
  assign wrStream.valid = holdWrValid;
  assign wrStream.data  = {txNinthBit, holdWrData}; // R20
  assign holdWrReady    = wrStream.ready;

  uat_fifo #(
    .WIDTH (uat_pkg::CHAR_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk     (clk),
    .resetn  (resetn),
    .flush   (portClear),
    .inPort  (wrStream),
    .outPort (rdStream)
  );

  // ==========================================================
  // state
  uat_pkg::uat_state_type state_ff;
  uat_pkg::uat_state_type nxt_state;
  logic                   holdFull_ff;
  logic [8:0]             holdData_ff;
  logic [8:0]             shift_ff;
  logic [8:0]             nxt_shift;
  logic [3:0]             bitCnt_ff;
  logic [3:0]             nxt_bitCnt;
  logic                   nineLatched_ff;
  logic                   line_ff;
  logic                   nxt_line;
  logic [GAP_W-1:0]       gapCnt_ff;
  logic [FLG_W-1:0]       fillCnt_ff;
  logic                   flag_ff;
  logic                   shiftEmpty_ff;
  logic                   pinOut_ff;

  wire stIdle  = (state_ff == uat_pkg::ST_IDLE);
  wire stStart = (state_ff == uat_pkg::ST_START);
  wire stData  = (state_ff == uat_pkg::ST_DATA);
  wire stStop  = (state_ff == uat_pkg::ST_STOP);
  wire stGap   = (state_ff == uat_pkg::ST_GAP);
  wire gapDone = stGap && (gapCnt_ff == GAP_LAST);

  // holding register takes from the buffer only while it is empty
  wire holdTake  = rdStream.valid && !holdFull_ff && txActive;
  assign rdStream.ready = holdTake;

  // idle shift register loads at once; a busy one waits out the gap
  wire loadShift = holdFull_ff && txActive && (stIdle || gapDone); // R10 R11
  wire lastBits  = nineLatched_ff ? (bitCnt_ff == BITS_WIDE) : (bitCnt_ff == BITS_NARROW);

  // ==========================================================
  // holding register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      holdFull_ff <= 1'b0;
      holdData_ff <= uat_pkg::HOLD_RESET;
    end else if (portClear) begin
      holdFull_ff <= 1'b0; // R24
    end else if (holdTake) begin
      holdFull_ff <= 1'b1;
      holdData_ff <= rdStream.data;
    end else if (loadShift) begin
      holdFull_ff <= 1'b0;
    end
  end

  // ==========================================================
  // frame sequencer
  always_comb begin
    nxt_state  = state_ff;
    nxt_shift  = shift_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_line   = line_ff;
    case (state_ff)
      uat_pkg::ST_IDLE: begin
        nxt_line = uat_pkg::MARK_LEVEL; // R01
        if (loadShift) begin
          nxt_state  = uat_pkg::ST_START; // R12
          nxt_shift  = holdData_ff;
          nxt_bitCnt = 4'h0;
          nxt_line   = uat_pkg::SPACE_LEVEL; // R02
        end
      end
      uat_pkg::ST_START: begin
        if (baudTick) begin // R25
          nxt_state  = uat_pkg::ST_DATA;
          nxt_line   = shift_ff[0]; // R03
          nxt_shift  = {1'b0, shift_ff[8:1]};
          nxt_bitCnt = 4'h1;
        end
      end
      uat_pkg::ST_DATA: begin
        if (baudTick) begin // R25
          if (lastBits) begin // R19
            nxt_state = uat_pkg::ST_STOP;
            nxt_line  = uat_pkg::MARK_LEVEL; // R02
          end else begin
            nxt_line   = shift_ff[0]; // R03
            nxt_shift  = {1'b0, shift_ff[8:1]};
            nxt_bitCnt = bitCnt_ff + 4'h1;
          end
        end
      end
      uat_pkg::ST_STOP: begin
        if (baudTick) begin // R25
          nxt_state = uat_pkg::ST_GAP;
        end
      end
      uat_pkg::ST_GAP: begin
        nxt_line = uat_pkg::MARK_LEVEL; // R01
        if (loadShift) begin
          nxt_state  = uat_pkg::ST_START; // R11 R12
          nxt_shift  = holdData_ff;
          nxt_bitCnt = 4'h0;
          nxt_line   = uat_pkg::SPACE_LEVEL;
        end else if (gapDone) begin
          nxt_state = uat_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = uat_pkg::ST_IDLE;
        nxt_line  = uat_pkg::MARK_LEVEL;
      end
    endcase
  end

  // a frame is abandoned when the transmitter loses its enables
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff  <= uat_pkg::ST_IDLE;
      shift_ff  <= uat_pkg::SHIFT_RESET;
      bitCnt_ff <= 4'h0;
      line_ff   <= uat_pkg::MARK_LEVEL;
    end else if (!txActive) begin
      state_ff  <= uat_pkg::ST_IDLE; // R07 R24
      bitCnt_ff <= 4'h0;
      line_ff   <= uat_pkg::MARK_LEVEL; // R01
    end else begin
      state_ff  <= nxt_state;
      shift_ff  <= nxt_shift;
      bitCnt_ff <= nxt_bitCnt;
      line_ff   <= nxt_line;
    end
  end

  // width is fixed per character so a mid-frame mode change cannot split it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nineLatched_ff <= 1'b0;
    end else if (loadShift) begin
      nineLatched_ff <= nineBitTxEnable; // R19
    end
  end

  // ==========================================================
  // one instruction cycle between stop bit and the next load
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gapCnt_ff <= '0;
    end else if (!stGap || gapDone) begin
      gapCnt_ff <= '0;
    end else begin
      gapCnt_ff <= gapCnt_ff + 1'b1; // R11
    end
  end

  // ==========================================================
  // status flags
  // fill age counts how long the holding register has been full
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fillCnt_ff <= '0;
    end else if (!holdFull_ff) begin
      fillCnt_ff <= '0;
    end else if (fillCnt_ff != FLG_LIMIT) begin
      fillCnt_ff <= fillCnt_ff + 1'b1; // R14
    end
  end

  // flag has no write path; the clear lags the fill on purpose
  wire flagHeld = holdFull_ff && (fillCnt_ff == FLG_LIMIT); // R14
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= txActive && !flagHeld; // R13 R15 R21
    end
  end

  // shift empty covers idle and the post-stop gap
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shiftEmpty_ff <= 1'b1;
    end else begin
      shiftEmpty_ff <= (nxt_state == uat_pkg::ST_IDLE) || (nxt_state == uat_pkg::ST_GAP) || !txActive; // R18
    end
  end

  assign txBufferEmptyFlag = flag_ff;
  assign shiftEmptyStatus  = shiftEmpty_ff;
  assign txIrqRequest      = flag_ff && txIrqEnable; // R16

  // ==========================================================
  // pin output
  wire pinSel = txActive ? (line_ff ^ clockPolaritySelect) : portLatchTx; // R23 R08
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinOut_ff <= uat_pkg::MARK_LEVEL;
    end else begin
      pinOut_ff <= pinSel;
    end
  end
  assign transmitPinOut = pinOut_ff;

  // no parity logic exists; parity, if any, rides in the ninth bit (R05)
  // frame format and tick are shared inputs, common with the receiver (R04 R06)
  wire unusedStates = stStart | stData | stStop;

endmodule // uat_tx

//--- sim/uat_rx_model.sv
`timescale 1ns/1ps

module uat_rx_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // line and format
  input  wire logic       baudTick,
  input  wire logic       pin,
  input  wire logic       invert,
  input  wire logic       nineBit,
  input  wire logic       active,
  // received character
  output logic            got,
  output logic [8:0]      data,
  output logic            stopOk
);
  logic       tick_ff;
  logic       act_ff;
  logic       inv_ff;
  logic [3:0] cnt_ff;
  logic [8:0] bits_ff;
  // invert is delayed to match the one-clock lag of the pin
  wire        lvl   = pin ^ inv_ff;
  wire  [3:0] nBits = nineBit ? 4'h9 : 4'h8;

  // ==========================================================
  // last sample of each bit lands one edge after its tick
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_ff <= 1'b0;
      act_ff  <= 1'b0;
      inv_ff  <= 1'b0;
      cnt_ff  <= 4'h0;
      bits_ff <= 9'h000;
      got     <= 1'b0;
      data    <= 9'h000;
      stopOk  <= 1'b0;
    end else begin
      tick_ff <= baudTick;
      act_ff  <= active;
      inv_ff  <= invert;
      got     <= 1'b0;
      // active lags one clock: the pin still shows the port latch on the first enabled edge
      if (!act_ff) begin
        cnt_ff <= 4'h0;
      end else if (tick_ff) begin
        if (cnt_ff == 4'h0) begin
          if (!lvl) begin
            cnt_ff  <= 4'h1;
            bits_ff <= 9'h000;
          end
        end else if (cnt_ff <= nBits) begin
          bits_ff[cnt_ff - 4'h1] <= lvl;
          cnt_ff <= cnt_ff + 4'h1;
        end else begin
          got    <= 1'b1;
          data   <= bits_ff;
          stopOk <= lvl;
          cnt_ff <= 4'h0;
        end
      end
    end
  end
endmodule // uat_rx_model

//--- sim/uat_tx_assertions.sv
`timescale 1ns/1ps

module uat_tx_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire logic serialPortEnable,
  input wire logic transmitEnableBit,
  input wire logic receiveEnableBit,
  input wire logic syncModeSelect,
  input wire logic clockPolaritySelect,
  input wire logic txIrqEnable,
  // writes and status
  input wire logic holdWrValid,
  input wire logic holdWrReady,
  input wire logic txBufferEmptyFlag,
  input wire logic shiftEmptyStatus,
  input wire logic txIrqRequest,
  // pins
  input wire logic pinDirectionBitTx,
  input wire logic transmitPinOut,
  input wire logic transmitPinOe,
  input wire logic pinDirectionBitRx,
  input wire logic receivePinOe
);
  wire txOn = serialPortEnable && transmitEnableBit && !syncModeSelect;
  wire rxOn = serialPortEnable && receiveEnableBit && !syncModeSelect;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // pins
  a_tx_pin_drive: assert property (txOn |-> transmitPinOe)
    else $error("tx pin not driven while active");
  a_tx_pin_dir: assert property (!txOn |-> transmitPinOe == !pinDirectionBitTx)
    else $error("tx pin direction wrong while inactive");
  a_rx_pin_input: assert property (rxOn |-> !receivePinOe)
    else $error("rx pin driven while receive active");
  a_idle_mark: assert property (txOn && $past(txOn) && $past(resetn) && $past(shiftEmptyStatus)
    && $stable(clockPolaritySelect) |-> transmitPinOut == (uat_pkg::MARK_LEVEL ^ clockPolaritySelect))
    else $error("idle line not at mark");
  a_start_space: assert property ($fell(shiftEmptyStatus) && txOn ##1 txOn && $stable(clockPolaritySelect)
    |-> transmitPinOut == (uat_pkg::SPACE_LEVEL ^ clockPolaritySelect))
    else $error("start bit missing after load");

  // ==========================================================
  // flags
  a_irq_gate_only: assert property (txIrqRequest == (txBufferEmptyFlag && txIrqEnable))
    else $error("irq request not flag and enable");
  a_flag_needs_tx: assert property (!txOn [*2] |-> !txBufferEmptyFlag)
    else $error("flag set while transmitter inactive");
  a_flag_idle_set: assert property ((txOn && shiftEmptyStatus) [*4] |-> txBufferEmptyFlag)
    else $error("flag clear with idle transmitter");
  a_flag_late_clear: assert property (holdWrValid && holdWrReady && txBufferEmptyFlag && txOn ##1 txOn
    |-> txBufferEmptyFlag)
    else $error("flag cleared at first cycle after write");
  a_port_off_reset: assert property (!serialPortEnable |=> shiftEmptyStatus && !txBufferEmptyFlag)
    else $error("port disable did not reset transmitter");
  a_port_off_ready: assert property (!serialPortEnable |-> !holdWrReady)
    else $error("write ready while port disabled");
endmodule // uat_tx_assertions

bind uat_tx uat_tx_assertions uat_tx_assertions_i (
  .clk(clk), .resetn(resetn), .serialPortEnable(serialPortEnable),
  .transmitEnableBit(transmitEnableBit), .receiveEnableBit(receiveEnableBit),
  .syncModeSelect(syncModeSelect), .clockPolaritySelect(clockPolaritySelect),
  .txIrqEnable(txIrqEnable), .holdWrValid(holdWrValid), .holdWrReady(holdWrReady),
  .txBufferEmptyFlag(txBufferEmptyFlag), .shiftEmptyStatus(shiftEmptyStatus),
  .txIrqRequest(txIrqRequest), .pinDirectionBitTx(pinDirectionBitTx),
  .transmitPinOut(transmitPinOut), .transmitPinOe(transmitPinOe),
  .pinDirectionBitRx(pinDirectionBitRx), .receivePinOe(receivePinOe));

//--- sim/uat_tx_tb.sv
`timescale 1ns/1ps

module uat_tx_tb;
  localparam int BIT = 8;
  logic       clk, resetn, portEn, transmit_enable_bit, rxEn, syncMode, polarity, nineBit;
  logic       ninth, irqEn, tick, wrValid, dirTx, latchTx, dirRx;
  logic [7:0] wrData;
  wire        ready, flag, shiftEmpty, irqReq, pinOut, pinOe, rxOe, got, stopOk;
  wire  [8:0] rxData;
  logic [8:0] expQ[$];
  int         n_fail, checked, tickCnt, n;

  uat_tx uat_tx_i (
    .clk(clk), .resetn(resetn), .serialPortEnable(portEn), .transmitEnableBit(transmit_enable_bit),
    .receiveEnableBit(rxEn), .syncModeSelect(syncMode), .clockPolaritySelect(polarity),
    .nineBitTxEnable(nineBit), .txNinthBit(ninth), .txIrqEnable(irqEn), .baudTick(tick),
    .holdWrValid(wrValid), .holdWrData(wrData), .holdWrReady(ready), .txBufferEmptyFlag(flag),
    .shiftEmptyStatus(shiftEmpty), .txIrqRequest(irqReq), .pinDirectionBitTx(dirTx),
    .portLatchTx(latchTx), .transmitPinOut(pinOut), .transmitPinOe(pinOe),
    .pinDirectionBitRx(dirRx), .receivePinOe(rxOe));

  uat_rx_model uat_rx_model_i (
    .clk(clk), .resetn(resetn), .baudTick(tick), .pin(pinOut), .invert(polarity),
    .nineBit(nineBit), .active(portEn && transmit_enable_bit && !syncMode), .got(got), .data(rxData),
    .stopOk(stopOk));

  // ==========================================================
  // clock, baud tick, free-running side inputs
  always #10 clk = ~clk;
  always @(negedge clk) begin
    tickCnt <= (tickCnt + 1) % BIT;
    tick    <= (tickCnt == BIT - 1);
    {rxEn, dirTx, latchTx, dirRx} <= 4'($urandom);
    irqEn   <= (expQ.size() != 0);
  end

  // ==========================================================
  // helpers
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [8:0] exp_char(input logic wide, input logic b9, input logic [7:0] d);
    return {wide ? b9 : 1'b0, d};
  endfunction

  task automatic end_of_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // request stays up until ready is sampled high; caller releases it
  task automatic send(input logic [7:0] d, input logic b9);
    int k;
    k = 0;
    @(negedge clk);
    wrValid = 1'b1;
    wrData  = d;
    ninth   = b9;
    do begin
      @(posedge clk);
      k++;
    end while (ready !== 1'b1 && k < 2000);
    if (ready !== 1'b1) check("write ready", {8'h00, ready}, 9'h001);
    expQ.push_back(exp_char(nineBit, b9, d));
  endtask

  task automatic release_wr();
    @(negedge clk);
    wrValid = 1'b0;
  endtask

  task automatic drain();
    int k;
    k = 0;
    while (expQ.size() != 0 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    if (expQ.size() != 0) check("drain left", 9'(expQ.size()), 9'h000);
    repeat (4) @(negedge clk);
  endtask

  // sampled mid-cycle so the model's one-clock strobe is settled
  always @(negedge clk) begin
    if (got === 1'b1) begin
      if (expQ.size() == 0) check("rx extra", 9'h001, 9'h000);
      else check("rx data", rxData, expQ.pop_front());
      check("rx stop", stopOk, 1'b1);
    end
  end

  initial begin
    #(40000 * 20);
    n_fail++;
    end_of_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    {clk, resetn, portEn, transmit_enable_bit, syncMode, polarity, nineBit, ninth, wrValid, tick} = '0;
    {rxEn, irqEn, dirTx, latchTx, dirRx} = '0;
    wrData = 8'h00;
    {n_fail, checked, tickCnt} = '0;
    void'($urandom(32'h9ad2));
    repeat (2) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    check("pin idle", pinOut, 1'b1);
    check("shift empty", shiftEmpty, 1'b1);
    check("flag off", flag, 1'b0);
    portEn = 1'b1;
    transmit_enable_bit   = 1'b1;
    repeat (3) @(negedge clk);
    check("flag on enable", flag, 1'b1);
    // every format and polarity, boundary bytes among random ones
    for (int b = 0; b < 8; b++) begin
      nineBit  = b[0];
      polarity = b[1];
      send(b == 3 ? 8'hff : 8'($urandom), b == 3 ? 1'b1 : 1'($urandom));
      send(b == 4 ? 8'h00 : 8'($urandom), 1'($urandom));
      release_wr();
      repeat (8) @(negedge clk);
      check("flag queued", flag, 1'b0);
      check("shift busy", shiftEmpty, 1'b0);
      send(8'($urandom), 1'($urandom));
      release_wr();
      drain();
      check("shift empty after", shiftEmpty, 1'b1);
      check("flag empty after", flag, 1'b1);
    end
    // fill the buffer while transmit is off, then let it drain
    polarity = 1'b0;
    transmit_enable_bit = 1'b0;
    n = 0;
    for (int k = 0; k < 40; k++) begin
      @(negedge clk);
      wrValid = 1'b1;
      {ninth, wrData} = 9'($urandom);
      @(posedge clk);
      if (ready !== 1'b1) break;
      expQ.push_back(exp_char(nineBit, ninth, wrData));
      n++;
    end
    release_wr();
    check("fifo room", 9'(n), 9'd17);
    check("no tx when off", shiftEmpty, 1'b1);
    transmit_enable_bit = 1'b1;
    drain();
    // abort a frame by disabling the port
    send(8'h5a, 1'b0);
    send(8'ha5, 1'b1);
    release_wr();
    repeat (30) @(negedge clk);
    portEn = 1'b0;
    repeat (2) @(negedge clk);
    check("abort shift", shiftEmpty, 1'b1);
    check("abort flag", flag, 1'b0);
    check("abort ready", ready, 1'b0);
    expQ.delete();
    portEn = 1'b1;
    send(8'h3c, 1'b1);
    release_wr();
    drain();
    // sync mode keeps the transmitter quiet
    syncMode = 1'b1;
    send(8'hc3, 1'b0);
    release_wr();
    repeat (60) @(negedge clk);
    check("sync idle", shiftEmpty, 1'b1);
    syncMode = 1'b0;
    drain();
    end_of_test();
  end
endmodule // uat_tx_tb
